/* File: hw/isd_defines.vh */
// Constants for the instruction subset decoder
`ifndef ISD_DEFINES_VH
`define ISD_DEFINES_VH

`define ISD_IW 14
`define ISD_PCW 13
`define ISD_DW 8
`define ISD_AW 7
// Q phases per instruction cycle
`define ISD_QPH 4
`define ISD_QLAST 2'h3
`define ISD_QEXEC 2'h2
// Opcode fields
`define ISD_BR_HI 13
`define ISD_BR_LO 11
`define ISD_BR_OP 3'h5
`define ISD_OP6_HI 13
`define ISD_OP6_LO 8
`define ISD_OP_INCSZ 6'h0f
`define ISD_OP_INC 6'h0a
`define ISD_OP_ORAR 6'h04
`define ISD_OP_MOVR 6'h08
`define ISD_OP_ORL 6'h38
`define ISD_OP4_HI 13
`define ISD_OP4_LO 10
`define ISD_OP_LDL 4'hc
`define ISD_OP_STA 7'h01
`define ISD_OP7_HI 13
`define ISD_OP7_LO 7
`define ISD_DBIT 7
`define ISD_K11_HI 10
`define ISD_K8_HI 7
`define ISD_LAT_HI 4
`define ISD_LAT_LO 3
`define ISD_RST_PC 13'h0000
`define ISD_RST_W 8'h00
`define ISD_DEC_W 4

`endif

/* File: hw/isd_regfile.v */
// Data register file, 128 bytes, registered read data
`default_nettype none
`include "isd_defines.vh"

module isd_regfile #(
  parameter AW = `ISD_AW,
  parameter DW = `ISD_DW
) (
  input wire i_clock,
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule // isd_regfile

`default_nettype wire

/* File: hw/isd_core.v */
// Fetch, decode and execute core for an eight-instruction subset
// Contract
// - Top bits 101 decode as absolute branch
// - Branch loads immediate into pc bits 10:0
// - Pc bits 12:11 come from high latch
// - Branch takes two cycles, one word
// - Inc_skip_zero increments, writes dest, flags unchanged
// - Zero result flushes next instruction as nop
// - Destination bit 0 selects acc, 1 register
// - Inc_reg increments to dest, updates zero
// - Or_literal_acc ORs literal into acc, zero
// - Or_acc_reg ORs acc with register, zero
// - Move_reg copies register to dest, zero
// - Load_literal_acc loads literal, ignores don't-cares
// - Store_acc_reg copies acc to register, no flags
// - Cycle is four periods; plain instructions one
`default_nettype none
`include "isd_defines.vh"

module isd_core #(
  parameter IW = `ISD_IW,
  parameter PCW = `ISD_PCW,
  parameter DW = `ISD_DW,
  parameter AW = `ISD_AW
) (
  input wire i_clock,
  input wire i_srst,
  input wire [IW-1:0] i_instr,
  input wire [DW-1:0] i_pc_high_latch,
  output reg [PCW-1:0] o_pc,
  output reg [DW-1:0] o_acc,
  output reg o_zero,
  output reg o_no_operation,
  output reg [1:0] o_qphase
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  localparam [`ISD_DEC_W-1:0] OP_NONE = 4'h0;
  localparam [`ISD_DEC_W-1:0] OP_BR = 4'h1;
  localparam [`ISD_DEC_W-1:0] OP_INCSZ = 4'h2;
  localparam [`ISD_DEC_W-1:0] OP_INC = 4'h3;
  localparam [`ISD_DEC_W-1:0] OP_ORL = 4'h4;
  localparam [`ISD_DEC_W-1:0] OP_ORAR = 4'h5;
  localparam [`ISD_DEC_W-1:0] OP_MOVR = 4'h6;
  localparam [`ISD_DEC_W-1:0] OP_LDL = 4'h7;
  localparam [`ISD_DEC_W-1:0] OP_STA = 4'h8;

  function [`ISD_DEC_W-1:0] decode;
    input [IW-1:0] ins;
    begin
      decode = OP_NONE;
      if (ins[`ISD_BR_HI:`ISD_BR_LO] == `ISD_BR_OP) begin
        decode = OP_BR;
      end else if (ins[`ISD_OP4_HI:`ISD_OP4_LO] == `ISD_OP_LDL) begin
        decode = OP_LDL;
      end else if (ins[`ISD_OP7_HI:`ISD_OP7_LO] == `ISD_OP_STA) begin
        decode = OP_STA;
      end else begin
        case (ins[`ISD_OP6_HI:`ISD_OP6_LO])
          `ISD_OP_INCSZ: decode = OP_INCSZ;
          `ISD_OP_INC: decode = OP_INC;
          `ISD_OP_ORL: decode = OP_ORL;
          `ISD_OP_ORAR: decode = OP_ORAR;
          `ISD_OP_MOVR: decode = OP_MOVR;
          default: decode = OP_NONE;
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Q phase counter and instruction latch
  // ----------------------------------------------------------------
  reg [1:0] q_r;
  reg [IW-1:0] ir_r;
  reg flush_r;
  reg [PCW-1:0] pc_r;
  reg [DW-1:0] w_r;
  reg z_r;

  wire [`ISD_DEC_W-1:0] op = decode(ir_r);
  wire [AW-1:0] faddr = ir_r[AW-1:0];
  wire dsel = ir_r[`ISD_DBIT];
  wire [DW-1:0] kbyte = ir_r[`ISD_K8_HI:0];
  wire [DW-1:0] fdata;
  reg [DW-1:0] res;
  reg rf_we;
  reg w_we;
  reg z_we;
  reg skip;
  reg branch;

  isd_regfile #(
    .AW(AW),
    .DW(DW)
  ) u_rf (
    .i_clock(i_clock),
    .i_raddr(faddr),
    .o_rdata(fdata),
    .i_we(rf_we),
    .i_waddr(faddr),
    .i_wdata(res)
  );

  // ----------------------------------------------------------------
  // Execute datapath
  // ----------------------------------------------------------------
  always @* begin
    res = fdata;
    rf_we = 1'b0;
    w_we = 1'b0;
    z_we = 1'b0;
    skip = 1'b0;
    branch = 1'b0;
    case (op)
      OP_BR: begin
        branch = 1'b1;
      end
      OP_INCSZ: begin
        res = fdata + 8'h01;
        skip = (res == 8'h00);
        rf_we = dsel;
        w_we = ~dsel;
      end
      OP_INC: begin
        res = fdata + 8'h01;
        rf_we = dsel;
        w_we = ~dsel;
        z_we = 1'b1;
      end
      OP_ORL: begin
        res = w_r | kbyte;
        w_we = 1'b1;
        z_we = 1'b1;
      end
      OP_ORAR: begin
        res = w_r | fdata;
        rf_we = dsel;
        w_we = ~dsel;
        z_we = 1'b1;
      end
      OP_MOVR: begin
        res = fdata;
        rf_we = dsel;
        w_we = ~dsel;
        z_we = 1'b1;
      end
      OP_LDL: begin
        res = kbyte;
        w_we = 1'b1;
      end
      OP_STA: begin
        res = w_r;
        rf_we = 1'b1;
      end
      default: begin
        res = fdata;
      end
    endcase
    // Only act once per cycle, and never in a flushed slot
    if (q_r != `ISD_QEXEC || flush_r) begin
      rf_we = 1'b0;
      w_we = 1'b0;
      z_we = 1'b0;
      skip = 1'b0;
      branch = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencing: fetch at end of each four-period cycle
  // ----------------------------------------------------------------
  reg take_flush_r;
  reg hold_pc_r;
  always @(posedge i_clock) begin
    if (i_srst) begin
      q_r <= 2'h0;
      ir_r <= {IW{1'b0}};
      flush_r <= 1'b1;
      take_flush_r <= 1'b0;
      hold_pc_r <= 1'b0;
      pc_r <= `ISD_RST_PC;
      w_r <= `ISD_RST_W;
      z_r <= 1'b0;
    end else begin
      q_r <= q_r + 2'h1;
      if (w_we) begin
        w_r <= res;
      end
      if (z_we) begin
        z_r <= (res == 8'h00);
      end
      if (skip || branch) begin
        take_flush_r <= 1'b1;
      end
      if (branch) begin
        hold_pc_r <= 1'b1;
        pc_r <= {i_pc_high_latch[`ISD_LAT_HI:`ISD_LAT_LO], ir_r[`ISD_K11_HI:0]};
      end
      if (q_r == `ISD_QLAST) begin
        ir_r <= i_instr;
        flush_r <= take_flush_r;
        take_flush_r <= 1'b0;
        hold_pc_r <= 1'b0;
        // Skip still steps past the discarded word; branch keeps its target
        if (!hold_pc_r) begin
          pc_r <= pc_r + 13'h0001;
        end
      end
    end
  end

  always @(posedge i_clock) begin
    if (i_srst) begin
      o_pc <= `ISD_RST_PC;
      o_acc <= `ISD_RST_W;
      o_zero <= 1'b0;
      o_no_operation <= 1'b1;
      o_qphase <= 2'h0;
    end else begin
      o_pc <= pc_r;
      o_acc <= w_r;
      o_zero <= z_r;
      o_no_operation <= flush_r;
      o_qphase <= q_r;
    end
  end

endmodule // isd_core

`default_nettype wire

/* File: dv/isd_prog_mem.sv */
// Program memory model feeding the core's instruction port
`default_nettype none
module isd_prog_mem (
  input wire logic [12:0] i_addr,
  output wire logic [13:0] o_word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [13:0] mem [0:63] = '{default: 14'h0};
  assign o_word = mem[i_addr[5:0]];
endmodule // isd_prog_mem
`default_nettype wire

/* File: dv/isd_chk_assertions.sv */
// Port checker for the subset core
`default_nettype none
module isd_chk (
  input wire i_clock,
  input wire i_srst,
  input wire [13:0] i_instr,
  input wire [7:0] i_pc_high_latch,
  input wire [12:0] o_pc,
  input wire [7:0] o_acc,
  input wire o_zero,
  input wire o_no_operation,
  input wire [1:0] o_qphase
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  wire [13:0] w = i_instr;
  // ----
  // Fetch not shadowed by branch or skip
  // ----
  sequence fetch;
    o_qphase == 2'h2 && $past(w[13:11], 4) != 3'h5 && $past(w[13:8], 4) != 6'h0f;
  endsequence
  q_step_a: assert property (!$past(i_srst) && !$past(i_srst, 2) |-> o_qphase == $past(o_qphase) + 2'h1)
    else $error("phase skip");
  exec_phase_a: assert property (!$stable(o_acc) || !$stable(o_zero) |-> o_qphase == 2'h3)
    else $error("late result");
  ldl_acc_a: assert property (fetch ##0 w[13:10] == 4'hc |->
    ##5 o_acc == $past(w[7:0], 5) && $stable(o_zero)) else $error("bad load");
  orl_acc_a: assert property (fetch ##0 w[13:8] == 6'h38 |->
    ##5 o_acc == ($past(o_acc) | $past(w[7:0], 5))) else $error("bad or");
  br_target_a: assert property (fetch ##0 w[13:11] == 3'h5 |->
    ##5 o_pc == {$past(i_pc_high_latch[4:3], 2), $past(w[10:0], 5)}) else $error("bad target");
  br_flush_a: assert property (fetch ##0 w[13:11] == 3'h5 |-> ##2 $stable(o_acc) [*8])
    else $error("branch shadow ran");
  skip_flush_a: assert property (fetch ##0 w[13:7] == 7'h1e ##5 o_acc == 8'h0 |->
    ##1 $stable(o_acc) [*4]) else $error("skip shadow ran");
  zero_track_a: assert property (fetch ##0 w[13:7] inside {7'h14, 7'h08, 7'h10} |->
    ##5 o_zero == (o_acc == 8'h0)) else $error("bad zero");
  br_nop_a: assert property (fetch ##0 w[13:11] == 3'h5 |-> ##6 o_no_operation)
    else $error("branch slot not flushed");
  slot_live_a: assert property (fetch |-> ##2 !o_no_operation)
    else $error("plain slot flushed");
endmodule // isd_chk
bind isd_core isd_chk isd_chk_inst (.i_clock, .i_srst, .i_instr, .i_pc_high_latch, .o_pc, .o_acc, .o_zero,
  .o_no_operation, .o_qphase);
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the subset core
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] latch = 8'h00;
  wire [13:0] instr;
  wire [12:0] pc;
  wire [7:0] acc;
  wire zero;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #2 i_clock = ~i_clock;
  isd_prog_mem isd_prog_mem_inst (.i_addr(pc), .o_word(instr));
  isd_core isd_core_inst (.i_clock(i_clock), .i_srst(i_srst), .i_instr(instr), .i_pc_high_latch(latch),
    .o_pc(pc), .o_acc(acc), .o_zero(zero), .o_no_operation(), .o_qphase());
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic run(input logic [7:0] l, input logic [13:0] p [0:8]);
    @(negedge i_clock);
    foreach (p[i]) isd_prog_mem_inst.mem[i] = p[i];
    latch = l;
    i_srst = 1'b1;
    repeat (10) @(negedge i_clock);
    i_srst = 1'b0;
    repeat (90) @(negedge i_clock);
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      wrap_up();
    end
  end
  // ----
  // Scenarios
  // ----
  task automatic lit_branch();
    run(8'h18, '{14'h305a, 14'h3835, 14'h2802, 14'h3000, 0, 0, 0, 0, 0});
    chk("acc", acc, 8'h7f);
    chk("zero", zero, 8'h00);
    chk("pc_top", pc[12:11], 8'h03);
  endtask
  task automatic skip_taken();
    run(8'h00, '{14'h30ff, 14'h00a0, 14'h3001, 14'h0fa0, 14'h3880, 14'h04a0, 14'h0aa0, 14'h0820, 14'h2808});
    chk("acc", acc, 8'h02);
    chk("zero", zero, 8'h00);
  endtask
  task automatic skip_to_acc();
    run(8'h00, '{14'h30ff, 14'h00b0, 14'h0f30, 14'h3055, 14'h0ab0, 14'h0430, 14'h2806, 0, 0});
    chk("acc", acc, 8'h00);
    chk("zero", zero, 8'h01);
  endtask
  initial begin
    lit_branch();
    skip_taken();
    skip_to_acc();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
